// ==== core/lemr_regs.sv ====
// Link error monitor register bank with lock, frame start and pulldown logic
`timescale 1ns/100ps
`include "lemr_defs.svh"

module lemr_regs #(
	parameter int GPIO_N = 7                    // Number of GPIO pins
) (
	input  wire logic                 core_clk_in,      // 125 MHz clock
	input  wire logic                 reset_in,         // Async, active high
	input  wire logic [7:0]           reg_addr_in,      // Register address
	input  wire lemr_pkg::lemr_byte_t reg_wdata_in,     // Write data
	input  wire logic                 reg_wr_in,        // Write strobe
	input  wire logic                 reg_rd_in,        // Read strobe
	output      lemr_pkg::lemr_byte_t reg_rdata_out,    // Read data, next cycle
	input  wire logic                 pix_en_in,        // Recovered pixel tick
	input  wire logic                 parity_err_in,    // Forward parity error
	input  wire logic                 clock_err_in,     // Forward clock error
	input  wire logic                 control_err_in,   // Forward control error
	input  wire logic                 filter_wait_in,   // Equalizer filter wait
	input  wire logic                 lock_raw_in,      // Analog lock acquired
	output      logic                 lock_out,         // Receiver lock
	input  wire logic                 enc_valid_in,     // Encoded packet strobe
	input  wire logic                 enc_crc_ok_in,    // Packet check passed
	input  wire lemr_pkg::lemr_byte_t enc_info_in,      // Packet link info
	output      lemr_pkg::lemr_byte_t link_info_out,    // Stored link info
	input  wire logic                 raw_mode_in,      // Raw input mode
	input  wire logic                 link_clk_en_in,   // Link clock tick
	input  wire logic                 frame_active_in,  // Frame valid pin
	output      logic                 frame_start_out,  // Frame start pulse
	input  wire logic [GPIO_N-1:0]    gpio_is_out_in,   // Pin in output mode
	output      logic [GPIO_N-1:0]    pulldown_en_out,  // Pulldown enables
	output      logic                 irq_out           // Level interrupt
);
	import lemr_pkg::*;

	// Synchronised pin and link-side inputs
	logic [6:0] sync1_r;                        // First stage only
	logic [6:0] sync2_r;                        // Safe to read
	logic       fv_q, lk_q, pe_q, ce_q, te_q, fw_q, tk_q;

	// Register file state
	lemr_byte_t err_ctl_r, err_ctl_nxt;         // Monitor control
	lemr_byte_t enc_ctl_r, enc_ctl_nxt;         // Encoder check control
	lemr_byte_t rsvd_bb_r, rsvd_bb_nxt;         // Reserved, kept as RW
	lemr_byte_t fv_min_r, fv_min_nxt;           // Frame-active minimum
	lemr_byte_t rsvd_bd_r, rsvd_bd_nxt;         // Reserved RW
	lemr_byte_t pd_ctl_r, pd_ctl_nxt;           // Pulldown disables
	lemr_byte_t rsvd_bf_r, rsvd_bf_nxt;         // Reserved RW
	lemr_byte_t irq_sts_r, irq_sts_nxt;         // Sticky events
	lemr_byte_t irq_mask_r, irq_mask_nxt;       // Interrupt enables
	lemr_byte_t rdata_r, rdata_nxt;             // Read data register

	// Monitor state
	logic [3:0] err_cnt_r, err_cnt_nxt;         // Link error counter
	logic       lock_r, lock_nxt;               // Lock state
	lemr_byte_t info_r, info_nxt;               // Stored link info
	lemr_fv_state_t fv_st_r, fv_st_nxt;         // Frame start FSM
	lemr_byte_t fv_cnt_r, fv_cnt_nxt;           // Frame-active length
	logic       fs_r, fs_nxt;                   // Frame start pulse

	logic err_seen, lock_lost, lock_gain, crc_fail, fs_ev;

	// Decode used by both read and write paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction : hit

	// Two-flop synchronisers; async inputs come from the pins and the link side
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			sync1_r <= 7'h00;
			sync2_r <= 7'h00;
		end else begin
			sync1_r <= {frame_active_in, lock_raw_in, parity_err_in,
				clock_err_in, control_err_in, filter_wait_in, link_clk_en_in};
			sync2_r <= sync1_r;
		end
	end
	assign {fv_q, lk_q, pe_q, ce_q, te_q, fw_q, tk_q} = sync2_r;

	// Error detection and lock decision
	always_comb begin
		// Filter-wait errors dropped when the ignore bit is set
		err_seen = pix_en_in & (pe_q | ce_q | te_q)
			& ~(fw_q & err_ctl_r[`LEMR_BIT_FILT_IGNORE]);
		err_cnt_nxt = err_cnt_r;
		lock_nxt = lock_r;
		if (!err_ctl_r[`LEMR_BIT_CNT_EN]) begin
			err_cnt_nxt = 4'h0;
			if (err_seen && lock_r)
				lock_nxt = 1'b0;
		end else if (err_seen && lock_r) begin
			err_cnt_nxt = err_cnt_r + 4'h1;
			// Limit of zero behaves like a limit of one
			if (err_cnt_nxt >= err_ctl_r[3:0])
				lock_nxt = 1'b0;
		end
		if (!lock_r && lk_q && !err_seen) begin
			lock_nxt = 1'b1;
			err_cnt_nxt = 4'h0;
		end
		if (!lk_q)
			lock_nxt = 1'b0;
		lock_lost = lock_r & ~lock_nxt;
		lock_gain = ~lock_r & lock_nxt;
	end

	// Encoded packet acceptance
	always_comb begin
		info_nxt = info_r;
		crc_fail = enc_valid_in & ~enc_crc_ok_in;
		// Bypass accepts everything; checking drops failed packets
		if (enc_valid_in && (enc_crc_ok_in
			|| enc_ctl_r[`LEMR_BIT_ENC_OFF]))
			info_nxt = enc_info_in;
	end

	// Frame start generator for raw mode
	always_comb begin
		fv_st_nxt = fv_st_r;
		fv_cnt_nxt = fv_cnt_r;
		fs_nxt = 1'b0;
		case (fv_st_r)
			LEMR_FV_IDLE: begin
				fv_cnt_nxt = 8'h00;
				if (fv_q && raw_mode_in)
					fv_st_nxt = LEMR_FV_WAIT;
			end
			LEMR_FV_WAIT: begin
				if (!fv_q || !raw_mode_in) begin
					fv_st_nxt = LEMR_FV_IDLE;   // Short frame, no start
				end else if (tk_q) begin
					if (fv_cnt_r + 8'h01 >= fv_min_r) begin
						fs_nxt = 1'b1;
						fv_st_nxt = LEMR_FV_SENT;
					end else begin
						fv_cnt_nxt = fv_cnt_r + 8'h01;
					end
				end
			end
			LEMR_FV_SENT: begin
				if (!fv_q)
					fv_st_nxt = LEMR_FV_IDLE;
			end
			default: fv_st_nxt = LEMR_FV_IDLE;
		endcase
		fs_ev = fs_nxt;
	end

	// Register writes, reads and sticky status
	always_comb begin
		err_ctl_nxt = err_ctl_r;
		enc_ctl_nxt = enc_ctl_r;
		rsvd_bb_nxt = rsvd_bb_r;
		fv_min_nxt = fv_min_r;
		rsvd_bd_nxt = rsvd_bd_r;
		pd_ctl_nxt = pd_ctl_r;
		rsvd_bf_nxt = rsvd_bf_r;
		irq_mask_nxt = irq_mask_r;
		irq_sts_nxt = irq_sts_r;
		rdata_nxt = 8'h00;
		if (reg_wr_in) begin
			// Read-only reserved bits masked off on write
			if (hit(reg_addr_in, `LEMR_ADDR_ERR_CTL))
				err_ctl_nxt = reg_wdata_in & `LEMR_MASK_ERR_CTL;
			if (hit(reg_addr_in, `LEMR_ADDR_ENC_CTL))
				enc_ctl_nxt = reg_wdata_in;
			if (hit(reg_addr_in, `LEMR_ADDR_RSVD_BB))
				rsvd_bb_nxt = reg_wdata_in;
			if (hit(reg_addr_in, `LEMR_ADDR_FV_MIN))
				fv_min_nxt = reg_wdata_in;
			if (hit(reg_addr_in, `LEMR_ADDR_RSVD_BD))
				rsvd_bd_nxt = reg_wdata_in;
			if (hit(reg_addr_in, `LEMR_ADDR_PD_CTL))
				pd_ctl_nxt = reg_wdata_in & `LEMR_MASK_PD_CTL;
			if (hit(reg_addr_in, `LEMR_ADDR_RSVD_BF))
				rsvd_bf_nxt = reg_wdata_in;
			if (hit(reg_addr_in, `LEMR_ADDR_IRQ_MASK))
				irq_mask_nxt = {4'h0, reg_wdata_in[3:0]};
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				`LEMR_ADDR_ERR_CTL:  rdata_nxt = err_ctl_r;
				`LEMR_ADDR_ENC_CTL:  rdata_nxt = enc_ctl_r;
				`LEMR_ADDR_RSVD_BB:  rdata_nxt = rsvd_bb_r;
				`LEMR_ADDR_FV_MIN:   rdata_nxt = fv_min_r;
				`LEMR_ADDR_RSVD_BD:  rdata_nxt = rsvd_bd_r;
				`LEMR_ADDR_PD_CTL:   rdata_nxt = pd_ctl_r;
				`LEMR_ADDR_RSVD_BF:  rdata_nxt = rsvd_bf_r;
				`LEMR_ADDR_IRQ_STS:  rdata_nxt = irq_sts_r;
				`LEMR_ADDR_IRQ_MASK: rdata_nxt = irq_mask_r;
				`LEMR_ADDR_STATUS:   rdata_nxt = {3'h0, lock_r, err_cnt_r};
				default:             rdata_nxt = 8'h00; // Unmapped
			endcase
			// Read clears status; new events below still win
			if (hit(reg_addr_in, `LEMR_ADDR_IRQ_STS))
				irq_sts_nxt = 8'h00;
		end
		if (lock_lost) irq_sts_nxt[`LEMR_IRQ_LOCK_LOST] = 1'b1;
		if (crc_fail)  irq_sts_nxt[`LEMR_IRQ_CRC_FAIL] = 1'b1;
		if (fs_ev)     irq_sts_nxt[`LEMR_IRQ_FRAME_START] = 1'b1;
		if (lock_gain) irq_sts_nxt[`LEMR_IRQ_LOCK_GAINED] = 1'b1;
	end

	// State registers
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			err_ctl_r  <= `LEMR_RST_ERR_CTL;
			enc_ctl_r  <= `LEMR_RST_ENC_CTL;
			rsvd_bb_r  <= `LEMR_RST_RSVD_BB;
			fv_min_r   <= `LEMR_RST_FV_MIN;
			rsvd_bd_r  <= 8'h00;
			pd_ctl_r   <= `LEMR_RST_PD_CTL;
			rsvd_bf_r  <= 8'h00;
			irq_sts_r  <= 8'h00;
			irq_mask_r <= 8'h00;
			rdata_r    <= 8'h00;
			err_cnt_r  <= 4'h0;
			lock_r     <= 1'b0;
			info_r     <= 8'h00;
			fv_st_r    <= LEMR_FV_IDLE;
			fv_cnt_r   <= 8'h00;
			fs_r       <= 1'b0;
		end else begin
			err_ctl_r  <= err_ctl_nxt;
			enc_ctl_r  <= enc_ctl_nxt;
			rsvd_bb_r  <= rsvd_bb_nxt;
			fv_min_r   <= fv_min_nxt;
			rsvd_bd_r  <= rsvd_bd_nxt;
			pd_ctl_r   <= pd_ctl_nxt;
			rsvd_bf_r  <= rsvd_bf_nxt;
			irq_sts_r  <= irq_sts_nxt;
			irq_mask_r <= irq_mask_nxt;
			rdata_r    <= rdata_nxt;
			err_cnt_r  <= err_cnt_nxt;
			lock_r     <= lock_nxt;
			info_r     <= info_nxt;
			fv_st_r    <= fv_st_nxt;
			fv_cnt_r   <= fv_cnt_nxt;
			fs_r       <= fs_nxt;
		end
	end

	// Pulldown per pin: on unless output mode or disabled
	genvar g;
	generate
		for (g = 0; g < GPIO_N; g++) begin : g_pd
			assign pulldown_en_out[g] = ~gpio_is_out_in[g]
				& ~pd_ctl_r[g];
		end
	endgenerate

	assign reg_rdata_out   = rdata_r;
	assign lock_out        = lock_r;
	assign link_info_out   = info_r;
	assign frame_start_out = fs_r;
	assign irq_out         = |(irq_sts_r & irq_mask_r);

	// Checks on the design's own behaviour
	a_disabled_drop: assert property (@(posedge core_clk_in)
		disable iff (reset_in) (lock_r && err_seen
		&& !err_ctl_r[`LEMR_BIT_CNT_EN]) |=> !lock_r)
		else $error("lock kept after error with counting off");
	a_count_clear: assert property (@(posedge core_clk_in)
		disable iff (reset_in) !err_ctl_r[`LEMR_BIT_CNT_EN]
		|=> err_cnt_r == 4'h0)
		else $error("counter not cleared while disabled");
	a_filter_ignore: assert property (@(posedge core_clk_in)
		disable iff (reset_in) (fw_q && err_ctl_r[`LEMR_BIT_FILT_IGNORE]
		&& lock_r && lk_q) |=> lock_r)
		else $error("lock dropped during ignored filter wait");
	a_limit_drop: assert property (@(posedge core_clk_in)
		disable iff (reset_in) (lock_r && lk_q
		&& err_ctl_r[`LEMR_BIT_CNT_EN] && err_ctl_r[3:0] > err_cnt_r + 4'h1
		&& err_ctl_r[3:0] != 4'h0) |=> lock_r)
		else $error("lock dropped below the error limit");
	a_crc_block: assert property (@(posedge core_clk_in)
		disable iff (reset_in) (enc_valid_in && !enc_crc_ok_in
		&& !enc_ctl_r[`LEMR_BIT_ENC_OFF]) |=> $stable(info_r))
		else $error("failed packet updated link info");
	a_crc_bypass: assert property (@(posedge core_clk_in)
		disable iff (reset_in) (enc_valid_in
		&& enc_ctl_r[`LEMR_BIT_ENC_OFF]) |=> info_r == $past(enc_info_in))
		else $error("bypass did not store packet");
	a_fs_late: assert property (@(posedge core_clk_in)
		disable iff (reset_in) fs_r |-> $past(fv_cnt_r) + 8'h01
		>= fv_min_r)
		else $error("frame start before minimum time");
	a_pd_mask: assert property (@(posedge core_clk_in)
		disable iff (reset_in) (reg_wr_in && reg_addr_in ==
		`LEMR_ADDR_PD_CTL) |=> pd_ctl_r[7] == 1'b0)
		else $error("pulldown reserved bit stored");
	a_rsvd_zero: assert property (@(posedge core_clk_in)
		disable iff (reset_in) err_ctl_r[7:6] == 2'h0)
		else $error("reserved control bits nonzero");
	a_err_counts: assert property (@(posedge core_clk_in)
		disable iff (reset_in) (lock_r && lk_q && err_seen
		&& err_ctl_r[`LEMR_BIT_CNT_EN]) |=> (err_cnt_r != $past(err_cnt_r)
		|| !lock_r))
		else $error("error not counted");
	a_cnt_reset_one: assert property (@(posedge core_clk_in)
		$fell(reset_in) |-> err_ctl_r[`LEMR_BIT_CNT_EN])
		else $error("count enable not set after reset");

	c_lock_lost: cover property (@(posedge core_clk_in)
		disable iff (reset_in) lock_lost);
	c_frame_start: cover property (@(posedge core_clk_in)
		disable iff (reset_in) fs_r);
	c_crc_fail: cover property (@(posedge core_clk_in)
		disable iff (reset_in) crc_fail && !enc_ctl_r[`LEMR_BIT_ENC_OFF]);
	c_irq: cover property (@(posedge core_clk_in)
		disable iff (reset_in) irq_out);
endmodule : lemr_regs

// ==== core/lemr_defs.svh ====
// Register offsets, field positions, reset values for the link error monitor
`ifndef LEMR_DEFS_SVH
`define LEMR_DEFS_SVH
`define LEMR_ADDR_ERR_CTL     8'hB9
`define LEMR_ADDR_ENC_CTL     8'hBA
`define LEMR_ADDR_RSVD_BB     8'hBB
`define LEMR_ADDR_FV_MIN      8'hBC
`define LEMR_ADDR_RSVD_BD     8'hBD
`define LEMR_ADDR_PD_CTL      8'hBE
`define LEMR_ADDR_RSVD_BF     8'hBF
`define LEMR_ADDR_IRQ_STS     8'hC0
`define LEMR_ADDR_IRQ_MASK    8'hC1
`define LEMR_ADDR_STATUS      8'hC2
`define LEMR_BIT_FILT_IGNORE  5
`define LEMR_BIT_CNT_EN       4
`define LEMR_BIT_ENC_OFF      7
`define LEMR_RST_ERR_CTL      8'h33
`define LEMR_RST_ENC_CTL      8'h03
`define LEMR_RST_RSVD_BB      8'h74
`define LEMR_RST_FV_MIN       8'h80
`define LEMR_RST_PD_CTL       8'h00
`define LEMR_MASK_ERR_CTL     8'h3F
`define LEMR_MASK_PD_CTL      8'h7F
`define LEMR_IRQ_LOCK_LOST    0
`define LEMR_IRQ_CRC_FAIL     1
`define LEMR_IRQ_FRAME_START  2
`define LEMR_IRQ_LOCK_GAINED  3
`endif

// ==== core/lemr_pkg.sv ====
// Types shared by the link error monitor register bank
package lemr_pkg;
	typedef logic [7:0] lemr_byte_t;
	typedef enum logic [2:0] {
		LEMR_FV_IDLE = 3'b001,
		LEMR_FV_WAIT = 3'b010,
		LEMR_FV_SENT = 3'b100
	} lemr_fv_state_t;
endpackage : lemr_pkg

// ==== verification/lemr_far_model.sv ====
// Far-side serializer model: link errors, encoded packets, link ticks
`timescale 1ns/100ps

module lemr_far_model (
	input  wire logic       clk_in,       // Core clock
	output      logic       par_err_out,  // Parity error
	output      logic       clk_err_out,  // Clock error
	output      logic       ctl_err_out,  // Control error
	output      logic       pkt_vld_out,  // Packet strobe
	output      logic       pkt_ok_out,   // Packet check passed
	output      logic [7:0] pkt_info_out, // Packet link info
	output      logic       tick_out      // Link clock tick
);
	logic [1:0] div_r; // Tick divider

	// Quiet lines at time zero
	initial begin
		{par_err_out, clk_err_out, ctl_err_out} = 3'h0;
		{pkt_vld_out, pkt_ok_out, tick_out} = 3'h0;
		pkt_info_out = 8'h00;
		div_r = 2'h0;
	end

	// Link tick free-running, one core cycle in four
	always @(posedge clk_in) begin
		div_r <= div_r + 2'h1;
		tick_out <= (div_r == 2'h3);
	end

	// One-cycle error of kind 0 parity, 1 clock, 2 control
	task automatic send_err(input logic [1:0] kind);
		@(posedge clk_in);
		par_err_out <= (kind == 2'h0);
		clk_err_out <= (kind == 2'h1);
		ctl_err_out <= (kind == 2'h2);
		@(posedge clk_in);
		{par_err_out, clk_err_out, ctl_err_out} <= 3'h0;
	endtask : send_err

	// One packet; released lines show the inverse so nothing stale matches
	task automatic send_pkt(input logic [7:0] info, input logic ok);
		@(posedge clk_in);
		pkt_vld_out <= 1'b1;
		pkt_ok_out <= ok;
		pkt_info_out <= info;
		@(posedge clk_in);
		pkt_vld_out <= 1'b0;
		pkt_ok_out <= ~ok;
		pkt_info_out <= ~info;
	endtask : send_pkt
endmodule : lemr_far_model

// ==== verification/lemr_regs_bench.sv ====
// Self-checking bench for the link error monitor register bank
`timescale 1ns/100ps

module lemr_regs_bench;
	import lemr_pkg::*;
	logic       clk, rst, wr_s, rd_s;  // Clock, reset, strobes
	lemr_byte_t addr, wdata, rdata;    // Register bus
	logic       pe, ce, ke, fwait;     // Errors, filter wait
	logic       lraw, lock, ev, eok;   // Lock, packet qualifiers
	lemr_byte_t einfo, linfo;          // Packet info in and stored
	logic       tick, fact, fstart;    // Frame start path
	logic [6:0] gout, pden;            // Pin modes, pulldowns
	logic       irq;                   // Interrupt level
	logic       pix, raw;              // Pixel tick gate, raw input mode
	int         fails, num_checks;     // Score

	lemr_regs i_lemr_regs (.core_clk_in(clk), .reset_in(rst),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s),
		.reg_rd_in(rd_s), .reg_rdata_out(rdata), .pix_en_in(pix),
		.parity_err_in(pe), .clock_err_in(ce), .control_err_in(ke),
		.filter_wait_in(fwait), .lock_raw_in(lraw), .lock_out(lock),
		.enc_valid_in(ev), .enc_crc_ok_in(eok), .enc_info_in(einfo),
		.link_info_out(linfo), .raw_mode_in(raw), .link_clk_en_in(tick),
		.frame_active_in(fact), .frame_start_out(fstart),
		.gpio_is_out_in(gout), .pulldown_en_out(pden), .irq_out(irq));

	lemr_far_model i_lemr_far_model (.clk_in(clk), .par_err_out(pe),
		.clk_err_out(ce), .ctl_err_out(ke), .pkt_vld_out(ev),
		.pkt_ok_out(eok), .pkt_info_out(einfo), .tick_out(tick));

	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Compare and count; mismatch reported at once
	task automatic chk(input lemr_byte_t got, input lemr_byte_t exp);
		num_checks++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask : chk

	// Verdict and end of run
	task automatic tally_and_finish;
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	// Bus write; the extra edge keeps strobes from colliding
	task automatic bwr(input lemr_byte_t a, input lemr_byte_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : bwr

	// Bus read; data stands only in the cycle after the strobe
	task automatic brd(input lemr_byte_t a, output lemr_byte_t d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		d = rdata;
	endtask : brd

	// Bounded wait for a lock level; timeout ends the run
	task automatic wait_lock(input logic v);
		for (int n = 0; n < 60 && lock !== v; n++) @(posedge clk) #1;
		chk({7'h0, lock}, {7'h0, v});
		if (lock !== v)
			tally_and_finish();
	endtask : wait_lock

	// Reset values, masked bits, unmapped address
	task automatic t_regs;
		lemr_byte_t a[7] = '{8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF};
		lemr_byte_t e[7] = '{8'h33, 8'h03, 8'h74, 8'h80, 8'h00, 8'h00, 8'h00};
		lemr_byte_t v;
		foreach (a[i]) begin
			brd(a[i], v);
			chk(v, e[i]);
		end
		bwr(8'hB9, 8'hFF);
		brd(8'hB9, v);
		chk(v, 8'h3F);
		bwr(8'hBE, 8'hFF);
		brd(8'hBE, v);
		chk(v, 8'h7F);
		bwr(8'h10, 8'h5A);
		brd(8'h10, v);
		chk(v, 8'h00);
		bwr(8'hBE, 8'h00);
		$display("done: registers");
	endtask : t_regs

	// Threshold, count disable and filter-wait masking
	task automatic t_lock;
		logic held;
		lemr_byte_t v;
		bwr(8'hB9, 8'h32);
		@(posedge clk);
		lraw <= 1'b1;
		wait_lock(1'b1);
		i_lemr_far_model.send_err(2'h0);
		repeat (8) @(posedge clk) #1;
		chk({7'h0, lock}, 8'h01);
		// Status: lock set, one parity error counted
		brd(8'hC2, v);
		chk(v, 8'h11);
		i_lemr_far_model.send_err(2'h1);
		wait_lock(1'b0);
		wait_lock(1'b1);
		brd(8'hC2, v);
		chk(v, 8'h10);
		bwr(8'hB9, 8'h20);
		@(posedge clk);
		fwait <= 1'b1;
		i_lemr_far_model.send_err(2'h2);
		held = 1'b1;
		repeat (10) @(posedge clk) #1 held &= lock;
		chk({7'h0, held}, 8'h01);
		bwr(8'hB9, 8'h00);
		i_lemr_far_model.send_err(2'h2);
		wait_lock(1'b0);
		@(posedge clk);
		fwait <= 1'b0;
		wait_lock(1'b1);
		// No pixel tick: error must not reach the counting-off drop
		@(posedge clk);
		pix <= 1'b0;
		i_lemr_far_model.send_err(2'h0);
		held = 1'b1;
		repeat (8) @(posedge clk) #1 held &= lock;
		chk({7'h0, held}, 8'h01);
		@(posedge clk);
		pix <= 1'b1;
		$display("done: lock");
	endtask : t_lock

	// Packet check gate with interrupt raise, mask and clear
	task automatic t_enc;
		lemr_byte_t v;
		bwr(8'hBA, 8'h03);
		bwr(8'hC1, 8'h02);
		brd(8'hC0, v);
		i_lemr_far_model.send_pkt(8'hA5, 1'b1);
		#1;
		chk(linfo, 8'hA5);
		i_lemr_far_model.send_pkt(8'h5A, 1'b0);
		repeat (2) @(posedge clk) #1;
		chk(linfo, 8'hA5);
		chk({7'h0, irq}, 8'h01);
		brd(8'hC0, v);
		chk(v & 8'h02, 8'h02);
		chk({7'h0, irq}, 8'h00);
		bwr(8'hC1, 8'h00);
		bwr(8'hBA, 8'h83);
		i_lemr_far_model.send_pkt(8'h3C, 1'b0);
		repeat (2) @(posedge clk) #1;
		chk(linfo, 8'h3C);
		chk({7'h0, irq}, 8'h00);
		$display("done: packets");
	endtask : t_enc

	// Frame of len ticks against minimum n; pulses counted
	task automatic t_frame(input lemr_byte_t n, input int len,
			input lemr_byte_t exp);
		int t;
		lemr_byte_t p, at;
		bwr(8'hBC, n);
		t = 0;
		p = 8'h00;
		at = 8'h00;
		@(posedge clk);
		fact <= 1'b1;
		for (int c = 0; c < 300 && t < len; c++) begin
			@(posedge clk) #1;
			t += int'(tick);
			if (fstart === 1'b1) begin
				p++;
				at = t[7:0];
			end
		end
		// Tick budget ran out: counted as a mismatch
		if (t < len) begin
			chk(t[7:0], len[7:0]);
			tally_and_finish();
		end
		@(posedge clk);
		fact <= 1'b0;
		repeat (12) @(posedge clk) #1 p += {7'h0, fstart === 1'b1};
		chk(p, exp);
		chk({7'h0, at >= n || exp == 8'h00}, 8'h01);
		$display("done: frame min %0d", n);
	endtask : t_frame

	// Pulldown follows pin mode and disable bits
	task automatic t_pull;
		bwr(8'hBE, 8'h0F);
		@(posedge clk);
		gout <= 7'h55;
		@(posedge clk) #1;
		chk({1'b0, pden}, {1'b0, ~7'h55 & ~7'h0F});
		bwr(8'hBE, 8'h00);
		@(posedge clk) #1;
		chk({1'b0, pden}, {1'b0, ~7'h55});
		$display("done: pulldown");
	endtask : t_pull

	// Main sequence
	initial begin
		{rst, wr_s, rd_s, fwait, lraw, fact} = 6'h20;
		{addr, wdata, gout} = 23'h0;
		{pix, raw} = 2'h3;
		fails = 0;
		num_checks = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_lock();
		t_enc();
		t_frame(8'h03, 10, 8'h01);
		t_frame(8'h08, 2, 8'h00);
		// Raw mode off: a long frame still gives no start
		@(posedge clk);
		raw <= 1'b0;
		t_frame(8'h03, 10, 8'h00);
		@(posedge clk);
		raw <= 1'b1;
		t_pull();
		tally_and_finish();
	end
endmodule : lemr_regs_bench
